/* verilog/tsr_pkg.sv */
`default_nettype none

package tsr_pkg;

    // ----------------------------------------------------------------
    // Location map
    // ----------------------------------------------------------------
    localparam int          LOC_W      = 13;
    localparam int          RAM_DEPTH  = 8192;
    localparam logic [12:0] REG_BASE   = 13'h1ff8;
    localparam logic [12:0] OFF_CTL    = 13'h1ff8;
    localparam logic [12:0] OFF_SEC    = 13'h1ff9;
    localparam logic [12:0] OFF_MIN    = 13'h1ffa;
    localparam logic [12:0] OFF_HOUR   = 13'h1ffb;
    localparam logic [12:0] OFF_DAY    = 13'h1ffc;
    localparam logic [12:0] OFF_DATE   = 13'h1ffd;
    localparam logic [12:0] OFF_MONTH  = 13'h1ffe;
    localparam logic [12:0] OFF_YEAR   = 13'h1fff;

    // ----------------------------------------------------------------
    // Register indices and bit positions
    // ----------------------------------------------------------------
    localparam logic [2:0] IDX_CTL     = 3'h0;
    localparam logic [2:0] IDX_SEC     = 3'h1;
    localparam logic [2:0] IDX_DAY     = 3'h4;
    localparam int         SET_LOCK_BIT = 7;
    localparam int         FREEZE_BIT   = 6;
    localparam int         OSC_HALT_BIT = 7;
    localparam int         FREQ_TEST_BIT = 6;

    // Counter bits of each byte, index 0 is the control byte.
    localparam logic [7:0][7:0] FIELD_MASK = {
        8'hff, 8'h1f, 8'h3f, 8'h07, 8'h3f, 8'h7f, 8'h7f, 8'h00
    };

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0][7:0] REG_RESET = {
        8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00
    };

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ         = 10_000_000;
    localparam int TEST_FREQ_HZ   = 512;
    localparam int HALF_CYCLES    = CLK_HZ / (2 * TEST_FREQ_HZ);
    localparam int HALVES_PER_SEC = 2 * TEST_FREQ_HZ;

endpackage : tsr_pkg

`default_nettype wire

/* verilog/tsr_calendar.sv */
`timescale 1ns/1ps
`default_nettype none

module tsr_calendar #(
    parameter int HALF_CYCLES = tsr_pkg::HALF_CYCLES
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // Control
    input  wire logic            oscRun,
    input  wire logic            load,
    input  wire logic [7:1][7:0] loadValue,
    // Counters
    output logic      [7:1][7:0] count,
    output logic                 testWave
);

    typedef struct packed {
        logic [13:0]      divCnt;
        logic [9:0]       halfCnt;
        logic             wave;
        logic [7:1][7:0]  cnt;
    } tsr_cal_t;

    tsr_cal_t st;
    tsr_cal_t next_st;

    // ----------------------------------------------------------------
    // Arithmetic
    // ----------------------------------------------------------------
    function automatic logic [7:0] bcdInc(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
        if (v == last) begin
            bcdInc = first;
        end else if (v[3:0] == 4'h9) begin
            bcdInc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcdInc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    function automatic logic [7:0] lastDate(input logic [7:0] month,
                                            input logic [7:0] year);
        logic leap;
        leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                       : (year[3:0] == 4'h0 || year[3:0] == 4'h4 ||
                          year[3:0] == 4'h8);
        case (month)
            8'h02: begin
                lastDate = leap ? 8'h29 : 8'h28;
            end
            8'h04, 8'h06, 8'h09, 8'h11: begin
                lastDate = 8'h30;
            end
            default: begin
                lastDate = 8'h31;
            end
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Divider and counting
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (load) begin
            for (int i = 1; i < 8; i++) begin
                next_st.cnt[i] = loadValue[i] & tsr_pkg::FIELD_MASK[i];
            end
        end else if (oscRun) begin
            next_st.divCnt = st.divCnt + 14'h1;
            if (st.divCnt == 14'(HALF_CYCLES - 1)) begin
                next_st.divCnt  = 14'h0;
                next_st.wave    = ~st.wave;
                next_st.halfCnt = st.halfCnt + 10'h1;
                if (st.halfCnt == 10'(tsr_pkg::HALVES_PER_SEC - 1)) begin
                    next_st.halfCnt = 10'h0;
                    next_st.cnt[1] = bcdInc(st.cnt[1], 8'h59, 8'h00);
                    if (st.cnt[1] == 8'h59) begin
                        next_st.cnt[2] = bcdInc(st.cnt[2], 8'h59, 8'h00);
                        if (st.cnt[2] == 8'h59) begin
                            next_st.cnt[3] = bcdInc(st.cnt[3], 8'h23, 8'h00);
                            if (st.cnt[3] == 8'h23) begin
                                next_st.cnt[4] =
                                    bcdInc(st.cnt[4], 8'h07, 8'h01);
                                next_st.cnt[5] = bcdInc(st.cnt[5],
                                    lastDate(st.cnt[6], st.cnt[7]), 8'h01);
                                if (st.cnt[5] ==
                                    lastDate(st.cnt[6], st.cnt[7])) begin
                                    next_st.cnt[6] =
                                        bcdInc(st.cnt[6], 8'h12, 8'h01);
                                    if (st.cnt[6] == 8'h12) begin
                                        next_st.cnt[7] =
                                            bcdInc(st.cnt[7], 8'h99, 8'h00);
                                    end
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st.divCnt  <= 14'h0;
            st.halfCnt <= 10'h0;
            st.wave    <= 1'b0;
            st.cnt     <= tsr_pkg::REG_RESET[7:1];
        end else begin
            st <= next_st;
        end
    end

    assign count    = st.cnt;
    assign testWave = st.wave;

endmodule // tsr_calendar

`default_nettype wire

/* verilog/tsr_rtc.sv */
//
// Contract
// - 8192 bytes on 13 location lines; top eight are clock registers.
// - Time fields are packed BCD, hours in 24-hour form.
// - Month lengths and leap days are corrected through 2099.
// - User registers are a copy; internal counting runs unless the oscillator is halted.
// - Freeze bit (control bit 6) stops copying into user registers.
// - While frozen, user copy holds captured time; counters keep running.
// - After freeze clears, all user registers refresh within one second.
// - Set-lock bit (control bit 7) halts updates; host loads new time.
// - Clearing set-lock loads user values into counters, then counting.
// - Seconds bit 7 halts oscillator and timekeeping; writable anytime.
// - Day bit 6 with oscillator running makes seconds bit 0 toggle 512 Hz.
// - Sustained seconds read shows line zero toggling during frequency test.
// - Unassigned bits of clock bytes act as plain storage bits.
// - Read needs primary select low, output enable low, secondary high.
// - Read mode when store strobe high and select low; no handshake.
// - Data driven only with primary select and output enable active.
// - Supply fail deselects the device and floats the data pins.
// - Write mode with store strobe and select active; starts at later edge.
// - Supply fail flag is driven low while the supply is low.
//
`timescale 1ns/1ps
`default_nettype none

module tsr_rtc #(
    parameter int HALF_CYCLES = tsr_pkg::HALF_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Memory strobes
    input  wire logic [12:0] locationLines,
    input  wire logic        selectN,
    input  wire logic        secondarySelect,
    input  wire logic        outEnableN,
    input  wire logic        storeN,
    // Data pins
    input  wire logic [7:0]  dataIn,
    output logic      [7:0]  dataOut,
    output logic             dataOe,
    // Supply monitor
    input  wire logic        supplyLow,
    output logic             supplyFailFlagN
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [25:0]     pinSync1;
        logic [25:0]     pinSync2;
        logic            wrActive;
        logic [12:0]     wrLoc;
        logic [7:0]      wrData;
        logic [7:0][7:0] ureg;
        logic            lockPrev;
        logic            calLoad;
        logic [7:0]      dOut;
        logic            dOe;
        logic            pfN;
    } tsr_top_t;

    tsr_top_t st;
    tsr_top_t next_st;

    logic [7:0]      ram [0:tsr_pkg::RAM_DEPTH-1];
    logic            ramWe;
    logic [7:1][7:0] calCount;
    logic            calWave;

    // Synchronised pin view.
    logic [12:0] sLoc;
    logic        sSelN;
    logic        sSec;
    logic        sOeN;
    logic        sStoreN;
    logic [7:0]  sData;
    logic        sLow;

    assign {sLoc, sSelN, sSec, sOeN, sStoreN, sData, sLow} = st.pinSync2;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic isClockLoc(input logic [12:0] loc);
        isClockLoc = (loc >= tsr_pkg::REG_BASE);
    endfunction

    function automatic logic [7:0] mergeBits(input logic [7:0] keep,
                                             input logic [7:0] fresh,
                                             input logic [7:0] mask);
        mergeBits = (keep & ~mask) | (fresh & mask);
    endfunction

    // ----------------------------------------------------------------
    // Calendar counters
    // ----------------------------------------------------------------
    tsr_calendar #(
        .HALF_CYCLES (HALF_CYCLES)
    ) u_calendar (
        .clk       (clk),
        .rst_n     (rst_n),
        .oscRun    (~st.ureg[tsr_pkg::IDX_SEC][tsr_pkg::OSC_HALT_BIT]),
        .load      (st.calLoad),
        .loadValue (st.ureg[7:1]),
        .count     (calCount),
        .testWave  (calWave)
    );

    // ----------------------------------------------------------------
    // Access decode and register update
    // ----------------------------------------------------------------
    logic       selected;
    logic       writeNow;
    logic       readNow;
    logic       commit;
    logic       lockFall;
    logic [7:0] readByte;

    always_comb begin
        next_st = st;
        next_st.pinSync1 = {locationLines, selectN, secondarySelect,
                            outEnableN, storeN, dataIn, supplyLow};
        next_st.pinSync2 = st.pinSync1;

        selected = !sSelN && sSec && !sLow;
        writeNow = selected && !sStoreN;
        readNow  = selected && sStoreN && !sOeN;

        // The write condition opens at the later of the two edges; the
        // byte is stored from the last sampled data when it closes.
        next_st.wrActive = writeNow;
        if (writeNow) begin
            next_st.wrLoc  = sLoc;
            next_st.wrData = sData;
        end
        commit = st.wrActive && !writeNow;
        ramWe  = commit && !isClockLoc(st.wrLoc);

        if (commit && isClockLoc(st.wrLoc)) begin
            next_st.ureg[st.wrLoc[2:0]] = st.wrData;
        end

        // Clearing the set-lock bit hands the user copy to the counters.
        lockFall = st.lockPrev &&
                   !next_st.ureg[tsr_pkg::IDX_CTL][tsr_pkg::SET_LOCK_BIT];
        next_st.lockPrev =
            next_st.ureg[tsr_pkg::IDX_CTL][tsr_pkg::SET_LOCK_BIT];
        next_st.calLoad = lockFall;

        // Refresh only counter bits; free bits keep what was written.
        if (!next_st.ureg[tsr_pkg::IDX_CTL][tsr_pkg::FREEZE_BIT] &&
            !next_st.ureg[tsr_pkg::IDX_CTL][tsr_pkg::SET_LOCK_BIT] &&
            !lockFall && !st.calLoad) begin
            for (int i = 1; i < 8; i++) begin
                next_st.ureg[i] = mergeBits(next_st.ureg[i], calCount[i],
                    tsr_pkg::FIELD_MASK[i]);
            end
        end

        // Read path.
        if (isClockLoc(sLoc)) begin
            readByte = st.ureg[sLoc[2:0]];
            if (sLoc[2:0] == tsr_pkg::IDX_SEC &&
                st.ureg[tsr_pkg::IDX_DAY][tsr_pkg::FREQ_TEST_BIT] &&
                !st.ureg[tsr_pkg::IDX_SEC][tsr_pkg::OSC_HALT_BIT]) begin
                readByte[0] = calWave;
            end
        end else begin
            readByte = ram[sLoc];
        end
        next_st.dOut = readNow ? readByte : 8'h00;
        next_st.dOe  = readNow;
        next_st.pfN  = !sLow;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st.pinSync1 <= 26'h0;
            st.pinSync2 <= 26'h0;
            st.wrActive <= 1'b0;
            st.wrLoc    <= 13'h0;
            st.wrData   <= 8'h00;
            st.ureg     <= tsr_pkg::REG_RESET;
            st.lockPrev <= 1'b0;
            st.calLoad  <= 1'b0;
            st.dOut     <= 8'h00;
            st.dOe      <= 1'b0;
            st.pfN      <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Battery-backed storage has no reset.
    always_ff @(posedge clk) begin
        if (ramWe) begin
            ram[st.wrLoc] <= st.wrData;
        end
    end

    assign dataOut         = st.dOut;
    assign dataOe          = st.dOe;
    assign supplyFailFlagN = st.pfN;

endmodule // tsr_rtc

`default_nettype wire

/* test/tsr_rtc_props.sv */
`timescale 1ns/1ps
`default_nettype none

module tsr_rtc_props #(
    parameter int HALF_CYCLES = tsr_pkg::HALF_CYCLES
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Memory strobes
    input wire logic [12:0] locationLines,
    input wire logic        selectN,
    input wire logic        secondarySelect,
    input wire logic        outEnableN,
    input wire logic        storeN,
    input wire logic [7:0]  dataIn,
    // Device outputs and supply
    input wire logic [7:0]  dataOut,
    input wire logic        dataOe,
    input wire logic        supplyLow,
    input wire logic        supplyFailFlagN
);
    logic rdPin;
    logic wrPin;

    assign rdPin = !selectN && secondarySelect && !outEnableN && storeN
                   && !supplyLow;
    assign wrPin = !selectN && secondarySelect && !storeN;

    // ------------
    // Pin checks
    // ------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_read_drives: assert property (rdPin [*4] |=> dataOe)
        else $error("Data pins idle during a held read.");
    a_idle_floats: assert property (!rdPin [*4] |=> !dataOe)
        else $error("Data pins driven without a read.");
    a_idle_zero: assert property (!dataOe |-> dataOut == 8'h00)
        else $error("Read data not cleared while idle.");
    a_drive_cause: assert property ($rose(dataOe) |->
        $past(rdPin, 2) || $past(rdPin, 3) || $past(rdPin, 4))
        else $error("Data pins driven without a cause.");
    a_fail_desel: assert property (supplyLow [*4] |=> !dataOe)
        else $error("Device selected during supply fail.");
    a_flag_low: assert property ($rose(supplyLow) |->
        ##[2:4] !supplyFailFlagN)
        else $error("Supply fail flag not raised.");
    a_flag_back: assert property (!supplyLow [*4] |=> supplyFailFlagN)
        else $error("Supply fail flag stuck low.");
    a_write_quiet: assert property (wrPin [*4] |=> !dataOe)
        else $error("Data pins driven during a write.");
    a_second_gate: assert property (!secondarySelect [*4] |=> !dataOe)
        else $error("Read with secondary select low.");

    c_read: cover property (rdPin ##4 dataOe);
    c_write: cover property (wrPin [*4]);
    c_fail: cover property ($fell(supplyFailFlagN));
endmodule // tsr_rtc_props

`default_nettype wire

/* test/tsr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tsr_host_model (
    // Clock
    input  wire logic        clk,
    // Device read data
    input  wire logic [7:0]  dataOut,
    input  wire logic        dataOe,
    // Memory strobes
    output logic      [12:0] locationLines,
    output logic             selectN,
    output logic             secondarySelect,
    output logic             outEnableN,
    output logic             storeN,
    output logic      [7:0]  dataIn
);
    initial begin
        locationLines = 13'h0000;
        selectN = 1'b1;
        secondarySelect = 1'b1;
        outEnableN = 1'b1;
        storeN = 1'b1;
        dataIn = 8'h00;
    end

    // ------------
    // Bus cycles
    // ------------
    task automatic write_byte(input logic [12:0] loc, input logic [7:0] val);
        @(posedge clk);
        #1;
        locationLines = loc;
        dataIn = val;
        selectN = 1'b0;
        storeN = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        storeN = 1'b1;
        selectN = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        dataIn = ~val;
        locationLines = ~loc;
    endtask

    task automatic read_byte(input logic [12:0] loc, input logic sel2,
                             input int hold, output logic [7:0] val,
                             output logic oe, output int flips);
        logic [7:0] prev;
        @(posedge clk);
        #1;
        locationLines = loc;
        secondarySelect = sel2;
        selectN = 1'b0;
        outEnableN = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        val = dataOut;
        oe = dataOe;
        flips = 0;
        prev = dataOut;
        repeat (hold) begin
            @(posedge clk);
            #1;
            if (dataOut[0] !== prev[0]) begin
                flips++;
            end
            prev = dataOut;
        end
        selectN = 1'b1;
        outEnableN = 1'b1;
        secondarySelect = 1'b1;
        locationLines = ~loc;
        repeat (4) @(posedge clk);
    endtask
endmodule // tsr_host_model

`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb_top;
    localparam int HALF = 4;
    localparam int SEC = HALF * 1024;
    localparam logic [7:1][7:0] SET_VAL = 56'h00_02_28_07_23_59_59;
    localparam logic [7:1][7:0] ROLL_VAL = 56'h00_02_29_01_00_00_00;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supplyLow = 1'b0;
    logic [12:0] locationLines;
    logic selectN, secondarySelect, outEnableN, storeN;
    logic [7:0] dataIn, dataOut, rv, prevSec;
    logic dataOe, supplyFailFlagN, oe;
    int fails = 0;
    int checkCount = 0;
    int flips;

    always #50 clk = ~clk;

    tsr_rtc #(.HALF_CYCLES(HALF)) tsr_rtc_inst (.clk(clk), .rst_n(rst_n),
        .locationLines(locationLines), .selectN(selectN),
        .secondarySelect(secondarySelect), .outEnableN(outEnableN),
        .storeN(storeN), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .supplyLow(supplyLow),
        .supplyFailFlagN(supplyFailFlagN));
    tsr_host_model tsr_host_model_inst (.clk(clk), .dataOut(dataOut),
        .dataOe(dataOe), .locationLines(locationLines), .selectN(selectN),
        .secondarySelect(secondarySelect), .outEnableN(outEnableN),
        .storeN(storeN), .dataIn(dataIn));

    task automatic get(input logic [12:0] loc, input int hold = 0);
        tsr_host_model_inst.read_byte(loc, 1'b1, hold, rv, oe, flips);
    endtask

    task automatic put(input logic [12:0] loc, input logic [7:0] v);
        tsr_host_model_inst.write_byte(loc, v);
    endtask

    task automatic completeRun;
        $display("comparisons %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        completeRun;
    end

    // ------------
    // Scenarios
    // ------------
    initial begin
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            get(tsr_pkg::REG_BASE + 13'(i));
            `CHK("reset byte", tsr_pkg::REG_RESET[i], rv);
        end
        put(13'h0000, 8'ha5);
        put(13'h1ff7, 8'h3c);
        get(13'h0000);
        `CHK("ram low", 8'ha5, rv);
        `CHK("read drive", 1'b1, oe);
        get(13'h1ff7);
        `CHK("ram top", 8'h3c, rv);
        get(tsr_pkg::OFF_SEC);
        prevSec = rv;
        for (int n = 0; n < 600 && rv === prevSec; n++) get(tsr_pkg::OFF_SEC);
        `CHK("tick seen", 1'b1, rv !== prevSec);
        put(tsr_pkg::OFF_CTL, 8'h80);
        for (int i = 1; i < 8; i++) put(tsr_pkg::REG_BASE + 13'(i), SET_VAL[i]);
        put(tsr_pkg::OFF_CTL, 8'h00);
        put(tsr_pkg::OFF_CTL, 8'h40);
        for (int i = 1; i < 8; i++) begin
            get(tsr_pkg::REG_BASE + 13'(i));
            `CHK("loaded byte", SET_VAL[i], rv);
        end
        repeat (SEC) @(posedge clk);
        get(tsr_pkg::OFF_SEC);
        `CHK("frozen seconds", 8'h59, rv);
        put(tsr_pkg::OFF_CTL, 8'h00);
        put(tsr_pkg::OFF_CTL, 8'h40);
        for (int i = 1; i < 8; i++) begin
            get(tsr_pkg::REG_BASE + 13'(i));
            `CHK("rolled byte", ROLL_VAL[i], rv);
        end
        put(tsr_pkg::OFF_CTL, 8'h00);
        put(tsr_pkg::OFF_MIN, 8'h33);
        put(tsr_pkg::OFF_DAY, 8'h41);
        get(tsr_pkg::OFF_MIN);
        `CHK("overwritten minutes", 8'h00, rv);
        get(tsr_pkg::OFF_DAY);
        `CHK("free day bit", 8'h41, rv);
        get(tsr_pkg::OFF_SEC, 32);
        `CHK("test wave", 32 / HALF, flips);
        put(tsr_pkg::OFF_DAY, 8'h01);
        get(tsr_pkg::OFF_SEC, 32);
        `CHK("no wave", 1'b1, flips <= 1);
        put(tsr_pkg::OFF_CTL, 8'h80);
        put(tsr_pkg::OFF_SEC, 8'h85);
        put(tsr_pkg::OFF_CTL, 8'h00);
        repeat (SEC + 200) @(posedge clk);
        put(tsr_pkg::OFF_CTL, 8'h40);
        get(tsr_pkg::OFF_SEC);
        `CHK("halted seconds", 8'h85, rv);
        put(tsr_pkg::OFF_CTL, 8'h00);
        supplyLow = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK("fail flag", 1'b0, supplyFailFlagN);
        put(13'h0000, 8'h5a);
        get(13'h0000);
        `CHK("fail drive", 1'b0, oe);
        #1 supplyLow = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHK("flag back", 1'b1, supplyFailFlagN);
        get(13'h0000);
        `CHK("write dropped", 8'ha5, rv);
        tsr_host_model_inst.read_byte(13'h0000, 1'b0, 0, rv, oe, flips);
        `CHK("second select", 1'b0, oe);
        completeRun;
    end
endmodule // tb_top

bind tsr_rtc tsr_rtc_props #(.HALF_CYCLES(HALF_CYCLES)) tsr_rtc_props_inst (
    .clk(clk), .rst_n(rst_n), .locationLines(locationLines),
    .selectN(selectN), .secondarySelect(secondarySelect),
    .outEnableN(outEnableN), .storeN(storeN), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .supplyLow(supplyLow),
    .supplyFailFlagN(supplyFailFlagN));

`undef CHK
`default_nettype wire
